// file: src/flow_pkg.sv
package flow_pkg;
  // timing base
  localparam int CLK_MHZ = 250;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
  localparam int PULSE_MAX_MS = 1000;
  localparam int PULSE_MAX_CYCLES = PULSE_MAX_MS * 1000 * CLK_MHZ;
  localparam int INTEG_US = 1;
  localparam int INTEG_CYCLES = INTEG_US * CLK_MHZ;
  localparam int TRIM_S = 60;
  localparam int TRIM_TICKS = TRIM_S * 1000 / TICK_MS;
  // volume unit 1e-8 ml: flow in 0.01 ml/s summed once per microsecond
  localparam longint UNITS_PER_ML = 100000000 / INTEG_US;
  localparam longint UNITS_PER_PVAL = UNITS_PER_ML / 10;
  localparam int DAILY_WRAP_ML = 1000000000;
  localparam int ML_PER_TOTAL = 1000;
  localparam int CORR_SCALE = 1000;
  localparam int BAND_WIDTH = 1000;
  localparam int CREEP_UNIT = 10;
  localparam int CREEP_NUM = 3;
  localparam int CREEP_DEN = 4;
  // register offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CFG_OFF = 8'h04;
  localparam logic [7:0] DOSE_QTY_OFF = 8'h08;
  localparam logic [7:0] DOSE_TIME_OFF = 8'h0c;
  localparam logic [7:0] CORR_OFF = 8'h10;
  localparam logic [7:0] CREEP_THR_OFF = 8'h14;
  localparam logic [7:0] CREEP_LAG_OFF = 8'h18;
  localparam logic [7:0] HYST_OFF = 8'h1c;
  localparam logic [7:0] LOW_OFF = 8'h20;
  localparam logic [7:0] HIGH_OFF = 8'h24;
  localparam logic [7:0] PVAL_OFF = 8'h28;
  localparam logic [7:0] STATUS_OFF = 8'h2c;
  localparam logic [7:0] DAILY_OFF = 8'h30;
  localparam logic [7:0] TOTAL_OFF = 8'h34;
  localparam logic [7:0] OFFSET_OFF = 8'h38;
  localparam logic [7:0] FLOW_OFF = 8'h3c;
  localparam logic [7:0] POINTS_OFF = 8'h40;
  // field positions
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_OFFSET = 2;
  localparam int CMD_RESET = 3;
  localparam int CMD_TRIM = 4;
  localparam int CMD_WATER = 5;
  localparam int CFG_Q1 = 0;
  localparam int CFG_Q2 = 2;
  localparam int CFG_DI = 4;
  localparam int ST_DOSING = 0;
  localparam int ST_SUPP = 1;
  localparam int ST_LOW = 2;
  localparam int ST_HIGH = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_DONE = 5;
  localparam int ST_FAIL = 6;
  // ranges and reset values
  localparam logic [31:0] DOSE_QTY_MAX = 32'h003567e0;
  localparam logic [31:0] DOSE_TIME_MAX = 32'h000493e0;
  localparam int CORR_MAX = 500;
  localparam logic [31:0] CREEP_THR_MAX = 32'h00000d05;
  localparam logic [31:0] CREEP_LAG_MAX = 32'h000003e7;
  localparam logic [31:0] FLOW_LIM_MAX = 32'h000c3500;
  localparam logic [31:0] PVAL_MIN = 32'h00000001;
  localparam logic [31:0] PVAL_MAX = 32'h00007530;
  localparam logic [18:0] DOSE_TIME_RST = 19'h0001e;
  localparam logic [11:0] CREEP_THR_RST = 12'h00f;
  localparam logic [9:0] CREEP_LAG_RST = 10'h005;
  localparam logic [19:0] HIGH_RST = 20'h02710;
  localparam logic [14:0] PVAL_RST = 15'h000a;
  localparam logic [10:0] WATER_POINT = 11'h000;

  typedef enum logic [1:0] {
    out_pulse, out_dose, out_low, out_high
  } out_func_type;
  typedef enum logic [2:0] {
    di_none, di_dose, di_offset, di_reset, di_creep_off
  } di_func_type;
  typedef enum logic [1:0] {
    trim_idle, trim_run, trim_done, trim_fail
  } trim_state_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic di_meta;
    logic di_sync;
    logic di_prev;
    out_func_type q1_func;
    out_func_type q2_func;
    di_func_type di_func;
    logic [21:0] dose_qty;
    logic [18:0] dose_time;
    logic signed [10:0] corr;
    logic [11:0] creep_thr;
    logic [9:0] creep_lag;
    logic [19:0] hyst;
    logic [19:0] low_lim;
    logic [19:0] high_lim;
    logic [14:0] pval;
    logic [7:0][10:0] points;
    logic signed [31:0] raw;
    logic signed [31:0] offset;
    logic signed [31:0] flow;
    logic below;
    logic suppressed;
    logic [9:0] lag_cnt;
    logic low_flag;
    logic high_flag;
    logic [31:0] tick_cnt;
    logic tick;
    logic [7:0] integ_cnt;
    logic [47:0] pulse_acc;
    logic [31:0] ml_acc;
    logic [7:0] pend;
    logic [31:0] period_cnt;
    logic [31:0] high_len;
    logic [31:0] high_cnt;
    logic pulse_on;
    logic [29:0] daily;
    logic [9:0] total_ml;
    logic [31:0] total;
    logic dosing;
    logic [21:0] dose_ml;
    logic [18:0] dose_ticks;
    trim_state_type trim;
    logic [9:0] trim_ticks;
    logic trim_bad;
    logic q1;
    logic q2;
  } state_type;
endpackage : flow_pkg

// file: src/flow_pulse_dosing_control.sv
// Notes on behaviour
// - start command begins a dosing run, stop command aborts it.
// - dosing quantity 0 to 3500 l in 1 ml steps, default 0.
// - timeout 0 to 30000 s in 0.1 s, default 3 s, may end early.
// - timeout of zero disables the timer.
// - offset-set command captures the present reading as offset.
// - offset follows small drift by itself while flow is at zero.
// - one-point correction -50.0 to +50.0 percent, 0.1 percent steps.
// - suppress below 75 percent of threshold, release above threshold.
// - while suppressed no pulses, no totals, zero analog value.
// - creeping threshold 0 to 20 l/min in 0.006 l/min steps.
// - entry to suppression delayed by lag 0 to 99.9 s, default 0.5 s.
// - basic trim runs about a minute, then reports done or failure.
// - eight curve correction points describe the medium.
// - restore-water command loads factory values into all points.
// - counter reset clears daily counter, counting then goes on.
// - limit hysteresis 0 to 8000 ml/s in 0.01 ml/s, default 0.
// - limits 0 to 8000 ml/s; low defaults 0, high to rated flow.
// - one pulse per pulse value, 0.1 to 3000.0 ml, default 1.0 ml.
// - pulse rate must stay below 10 kHz and the receiver limit.
// - pulse high for half its period, at most one second.
// - total counter counts up only and is never cleared.
// - input rising edge starts dosing, sets offset or resets counter.
// - input held high in override function disables suppression.
module flow_pulse_dosing_control #(
  parameter int TICK_LEN = flow_pkg::TICK_CYCLES,
  parameter int PULSE_MAX = flow_pkg::PULSE_MAX_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [31:0] flow_raw,
  input wire logic flow_valid,
  input wire logic digital_input_one,
  output logic digital_output_one,
  output logic digital_output_two,
  output logic signed [31:0] analog_flow
);

  flow_pkg::state_type s;
  flow_pkg::state_type next_s;

  logic wr;
  logic hit;
  logic pt_hit;
  logic [2:0] pt_idx;
  logic [31:0] rd;
  logic di_rise;
  logic do_start;
  logic do_stop;
  logic do_offset;
  logic do_reset;
  logic override;
  logic step;
  logic pulse_evt;
  logic ml_step;
  logic signed [31:0] d;
  logic signed [31:0] f;
  logic [2:0] band;
  int c;
  longint prod;
  int thr;
  int low_thr;
  int sv;
  logic [31:0] half;

  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] hi);
    return (v > hi) ? hi : v;
  endfunction : clamp

  function automatic logic [31:0] mag(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction : mag

  // output function select shared by both digital outputs
  function automatic logic pick(input flow_pkg::out_func_type fn,
                                input flow_pkg::state_type st);
    case (fn)
      flow_pkg::out_pulse: return st.pulse_on;
      flow_pkg::out_dose: return st.dosing;
      flow_pkg::out_low: return st.low_flag;
      flow_pkg::out_high: return st.high_flag;
      default: return 1'b0;
    endcase
  endfunction : pick

  // register decode, shared by read and write
  assign pt_hit = (paddr >= flow_pkg::POINTS_OFF) &&
                  (paddr < flow_pkg::POINTS_OFF + 8'h20);
  assign pt_idx = paddr[4:2];

  // next-state logic; the whole block state lives in one struct
  always_comb begin
    next_s = s;
    rd = 32'h0;
    hit = 1'b1;
    sv = 0; // no latch: only the correction write uses it
    // zero wait state: ready is raised for the access cycle only
    next_s.pready = psel & ~penable;
    wr = psel & penable & s.pready & pwrite;
    case (paddr)
      flow_pkg::CTRL_OFF: rd = 32'h0;
      flow_pkg::CFG_OFF: begin
        rd[flow_pkg::CFG_Q1 +: 2] = s.q1_func;
        rd[flow_pkg::CFG_Q2 +: 2] = s.q2_func;
        rd[flow_pkg::CFG_DI +: 3] = s.di_func;
      end
      flow_pkg::DOSE_QTY_OFF: rd = 32'(s.dose_qty);
      flow_pkg::DOSE_TIME_OFF: rd = 32'(s.dose_time);
      flow_pkg::CORR_OFF: rd = 32'(s.corr);
      flow_pkg::CREEP_THR_OFF: rd = 32'(s.creep_thr);
      flow_pkg::CREEP_LAG_OFF: rd = 32'(s.creep_lag);
      flow_pkg::HYST_OFF: rd = 32'(s.hyst);
      flow_pkg::LOW_OFF: rd = 32'(s.low_lim);
      flow_pkg::HIGH_OFF: rd = 32'(s.high_lim);
      flow_pkg::PVAL_OFF: rd = 32'(s.pval);
      flow_pkg::STATUS_OFF: begin
        rd[flow_pkg::ST_DOSING] = s.dosing;
        rd[flow_pkg::ST_SUPP] = s.suppressed;
        rd[flow_pkg::ST_LOW] = s.low_flag;
        rd[flow_pkg::ST_HIGH] = s.high_flag;
        rd[flow_pkg::ST_BUSY] = s.trim == flow_pkg::trim_run;
        rd[flow_pkg::ST_DONE] = s.trim == flow_pkg::trim_done;
        rd[flow_pkg::ST_FAIL] = s.trim == flow_pkg::trim_fail;
      end
      flow_pkg::DAILY_OFF: rd = 32'(s.daily);
      flow_pkg::TOTAL_OFF: rd = s.total;
      flow_pkg::OFFSET_OFF: rd = s.offset;
      flow_pkg::FLOW_OFF: rd = s.flow;
      default: begin
        hit = pt_hit && paddr[1:0] == 2'b00;
        if (hit) begin
          rd = 32'($signed(s.points[pt_idx]));
        end
      end
    endcase
    // read data and error are set up in the setup cycle
    if (psel & ~penable) begin
      next_s.prdata = (hit & ~pwrite) ? rd : 32'h0;
      next_s.pslverr = ~hit;
    end else begin
      next_s.pslverr = 1'b0;
    end

    // configuration writes; out-of-range values saturate, except function codes and points, which keep their low bits
    if (wr && hit) begin
      case (paddr)
        flow_pkg::CFG_OFF: begin
          next_s.q1_func = flow_pkg::out_func_type'(
            pwdata[flow_pkg::CFG_Q1 +: 2]);
          next_s.q2_func = flow_pkg::out_func_type'(
            pwdata[flow_pkg::CFG_Q2 +: 2]);
          next_s.di_func = flow_pkg::di_func_type'(
            pwdata[flow_pkg::CFG_DI +: 3]);
        end
        flow_pkg::DOSE_QTY_OFF: next_s.dose_qty =
          22'(clamp(pwdata, flow_pkg::DOSE_QTY_MAX));
        flow_pkg::DOSE_TIME_OFF: next_s.dose_time =
          19'(clamp(pwdata, flow_pkg::DOSE_TIME_MAX));
        flow_pkg::CORR_OFF: begin
          sv = $signed(pwdata);
          if (sv > flow_pkg::CORR_MAX) begin
            sv = flow_pkg::CORR_MAX;
          end else if (sv < -flow_pkg::CORR_MAX) begin
            sv = -flow_pkg::CORR_MAX;
          end
          next_s.corr = 11'(sv);
        end
        flow_pkg::CREEP_THR_OFF: next_s.creep_thr =
          12'(clamp(pwdata, flow_pkg::CREEP_THR_MAX));
        flow_pkg::CREEP_LAG_OFF: next_s.creep_lag =
          10'(clamp(pwdata, flow_pkg::CREEP_LAG_MAX));
        flow_pkg::HYST_OFF: next_s.hyst =
          20'(clamp(pwdata, flow_pkg::FLOW_LIM_MAX));
        flow_pkg::LOW_OFF: next_s.low_lim =
          20'(clamp(pwdata, flow_pkg::FLOW_LIM_MAX));
        flow_pkg::HIGH_OFF: next_s.high_lim =
          20'(clamp(pwdata, flow_pkg::FLOW_LIM_MAX));
        flow_pkg::PVAL_OFF: begin
          next_s.pval = 15'(clamp(pwdata, flow_pkg::PVAL_MAX));
          if (pwdata < flow_pkg::PVAL_MIN) begin
            next_s.pval = 15'(flow_pkg::PVAL_MIN);
          end
        end
        default: begin
          if (pt_hit) begin
            next_s.points[pt_idx] = pwdata[10:0];
          end
        end
      endcase
    end

    // pin synchroniser and command sources
    next_s.di_meta = digital_input_one;
    next_s.di_sync = s.di_meta;
    next_s.di_prev = s.di_sync;
    di_rise = s.di_sync & ~s.di_prev;
    wr = wr && paddr == flow_pkg::CTRL_OFF;
    do_start = (wr && pwdata[flow_pkg::CMD_START]) ||
      (di_rise && s.di_func == flow_pkg::di_dose);
    do_stop = wr && pwdata[flow_pkg::CMD_STOP];
    do_offset = (wr && pwdata[flow_pkg::CMD_OFFSET]) ||
      (di_rise && s.di_func == flow_pkg::di_offset);
    do_reset = (wr && pwdata[flow_pkg::CMD_RESET]) ||
      (di_rise && s.di_func == flow_pkg::di_reset);
    override = s.di_sync &&
      s.di_func == flow_pkg::di_creep_off;

    // 0.1 s step for dosing timer, lag, trim and drift tracking
    next_s.tick = 1'b0;
    next_s.tick_cnt = s.tick_cnt + 32'h1;
    if (s.tick_cnt >= 32'(TICK_LEN - 1)) begin
      next_s.tick_cnt = 32'h0;
      next_s.tick = 1'b1;
    end

    // offset removal and curve correction in per mille
    d = flow_raw - s.offset;
    band = (mag(d) / flow_pkg::BAND_WIDTH > 7) ? 3'h7 :
      3'(mag(d) / flow_pkg::BAND_WIDTH);
    c = int'(s.corr) + int'($signed(s.points[band]));
    prod = longint'(d) * longint'(c) / flow_pkg::CORR_SCALE;
    f = d + 32'(prod);
    if (flow_valid) begin
      next_s.raw = flow_raw;
    end

    // creeping suppression with lag on entry
    thr = int'(s.creep_thr) * flow_pkg::CREEP_UNIT;
    low_thr = thr * flow_pkg::CREEP_NUM / flow_pkg::CREEP_DEN;
    if (flow_valid) begin
      next_s.below = int'(mag(f)) < low_thr;
    end
    if (override) begin
      next_s.suppressed = 1'b0;
      next_s.lag_cnt = 10'h0;
    end else if (s.suppressed) begin
      if (flow_valid && int'(mag(f)) > thr) begin
        next_s.suppressed = 1'b0;
        next_s.lag_cnt = 10'h0;
      end
    end else if (!next_s.below) begin
      next_s.lag_cnt = 10'h0;
    end else if (s.lag_cnt >= s.creep_lag) begin
      next_s.suppressed = 1'b1;
    end else if (s.tick) begin
      next_s.lag_cnt = s.lag_cnt + 10'h1;
    end
    if (flow_valid) begin
      next_s.flow = f;
    end
    if (next_s.suppressed) begin
      next_s.flow = 32'sh0;
    end

    // limit comparators with hysteresis
    if (s.flow < $signed(32'(s.low_lim))) begin
      next_s.low_flag = 1'b1;
    end else if (s.flow > $signed(32'(s.low_lim) + 32'(s.hyst))) begin
      next_s.low_flag = 1'b0;
    end
    if (s.flow > $signed(32'(s.high_lim))) begin
      next_s.high_flag = 1'b1;
    end else if (s.flow < $signed(32'(s.high_lim)) -
                 $signed(32'(s.hyst))) begin
      next_s.high_flag = 1'b0;
    end

    // drift tracking: one count per step toward the zero reading
    if (s.tick && s.suppressed && s.trim != flow_pkg::trim_run) begin
      if (s.raw > s.offset) begin
        next_s.offset = s.offset + 32'sh1;
      end else if (s.raw < s.offset) begin
        next_s.offset = s.offset - 32'sh1;
      end
    end
    if (do_offset) begin
      next_s.offset = s.raw;
    end

    // integration of forward flow only; suppressed flow is zero here
    step = s.integ_cnt >= 8'(flow_pkg::INTEG_CYCLES - 1);
    next_s.integ_cnt = step ? 8'h0 : s.integ_cnt + 8'h1;
    pulse_evt = 1'b0;
    ml_step = 1'b0;
    if (step && s.flow > 32'sh0) begin
      next_s.pulse_acc = s.pulse_acc + 48'(s.flow);
      next_s.ml_acc = s.ml_acc + 32'(s.flow);
    end
    // remainder stays in the accumulator for the next interval
    if (s.pulse_acc >= 48'(s.pval) *
        48'(flow_pkg::UNITS_PER_PVAL)) begin
      next_s.pulse_acc = next_s.pulse_acc - 48'(s.pval) *
        48'(flow_pkg::UNITS_PER_PVAL);
      pulse_evt = 1'b1;
    end
    if (s.ml_acc >= 32'(flow_pkg::UNITS_PER_ML)) begin
      next_s.ml_acc = next_s.ml_acc -
        32'(flow_pkg::UNITS_PER_ML);
      ml_step = 1'b1;
    end

    // pulse shaping; pulses due while one is still high wait in a queue of up to 255
    next_s.period_cnt = (s.period_cnt == 32'hffffffff) ?
      s.period_cnt : s.period_cnt + 32'h1;
    half = s.period_cnt >> 1;
    if (pulse_evt) begin
      next_s.period_cnt = 32'h0;
      next_s.high_len = (half > 32'(PULSE_MAX)) ?
        32'(PULSE_MAX) : half;
      if (half == 32'h0) begin
        next_s.high_len = 32'h1;
      end
    end
    if (s.pulse_on) begin
      next_s.high_cnt = s.high_cnt + 32'h1;
      if (s.high_cnt + 32'h1 >= s.high_len) begin
        next_s.pulse_on = 1'b0;
      end
    end else if (s.pend != 8'h0) begin
      next_s.pulse_on = 1'b1;
      next_s.high_cnt = 32'h0;
    end
    next_s.pend = s.pend - 8'((!s.pulse_on && s.pend != 8'h0) ? 1 : 0)
      + 8'((pulse_evt && s.pend != 8'hff) ? 1 : 0);

    // daily counter in ml, wraps at a million litres
    if (ml_step) begin
      next_s.daily = (s.daily >= 30'(flow_pkg::DAILY_WRAP_ML - 1)) ?
        30'h0 : s.daily + 30'h1;
      next_s.total_ml = s.total_ml + 10'h1;
      if (s.total_ml >= 10'(flow_pkg::ML_PER_TOTAL - 1)) begin
        next_s.total_ml = 10'h0;
        next_s.total = s.total + 32'h1;
      end
    end
    if (do_reset) begin
      next_s.daily = ml_step ? 30'h1 : 30'h0;
    end

    // dosing run; stop has priority over a start in the same cycle
    if (s.dosing) begin
      if (ml_step) begin
        next_s.dose_ml = s.dose_ml + 22'h1;
      end
      if (do_stop) begin
        next_s.dosing = 1'b0;
      end else if (s.dose_ml >= s.dose_qty) begin
        next_s.dosing = 1'b0;
      end else if (s.tick && s.dose_time != 19'h0) begin
        next_s.dose_ticks = s.dose_ticks + 19'h1;
        if (s.dose_ticks + 19'h1 >= s.dose_time) begin
          next_s.dosing = 1'b0;
        end
      end
    end else if (do_start && !do_stop) begin
      next_s.dosing = 1'b1;
      next_s.dose_ml = 22'h0;
      next_s.dose_ticks = 19'h0;
    end

    // basic trim: fails if flow is seen during the run
    if (wr && pwdata[flow_pkg::CMD_WATER]) begin
      next_s.points = {8{flow_pkg::WATER_POINT}};
    end
    case (s.trim)
      flow_pkg::trim_run: begin
        if (flow_valid && int'(mag(f)) > thr) begin
          next_s.trim_bad = 1'b1;
        end
        if (s.tick) begin
          next_s.trim_ticks = s.trim_ticks + 10'h1;
        end
        if (s.trim_ticks >= 10'(flow_pkg::TRIM_TICKS)) begin
          next_s.trim = s.trim_bad ? flow_pkg::trim_fail :
            flow_pkg::trim_done;
          if (!s.trim_bad) begin
            next_s.offset = s.raw;
          end
        end
      end
      default: begin
        if (wr && pwdata[flow_pkg::CMD_TRIM]) begin
          next_s.trim = flow_pkg::trim_run;
          next_s.trim_ticks = 10'h0;
          next_s.trim_bad = 1'b0;
        end
      end
    endcase

    next_s.q1 = pick(s.q1_func, s);
    next_s.q2 = pick(s.q2_func, s);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.q2_func <= flow_pkg::out_dose;
      s.dose_time <= flow_pkg::DOSE_TIME_RST;
      s.creep_thr <= flow_pkg::CREEP_THR_RST;
      s.creep_lag <= flow_pkg::CREEP_LAG_RST;
      s.high_lim <= flow_pkg::HIGH_RST;
      s.pval <= flow_pkg::PVAL_RST;
      s.points <= {8{flow_pkg::WATER_POINT}};
      s.high_len <= 32'h1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign digital_output_one = s.q1;
  assign digital_output_two = s.q2;
  assign analog_flow = s.flow;

endmodule : flow_pulse_dosing_control

// file: tb/flow_partner.sv
module flow_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic signed [31:0] rate,
  input wire logic pulse,
  output logic signed [31:0] flow_raw,
  output logic flow_valid,
  output int pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div;
  logic pulse_d;
  initial begin
    div = 4'h0;
    pulse_d = 1'b0;
    pulses = 0;
    flow_valid = 1'b0;
    flow_raw = 32'sh0;
  end
  // sensor sample every 16 cycles; between samples the bus shows junk
  always @(posedge pclk) begin
    div <= div + 4'h1;
    flow_valid <= (div == 4'h0) && presetn;
    flow_raw <= (div == 4'h0) ? rate : ~rate;
    pulse_d <= pulse;
    if (pulse && !pulse_d) begin
      pulses <= pulses + 1;
    end
  end
endmodule : flow_partner

// file: tb/flow_pulse_dosing_control_asserts.sv
module flow_pulse_dosing_control_asserts #(
  parameter int PULSE_MAX = 1000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic digital_output_one,
  input wire logic digital_output_two
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // length of the present high phase of the pulse output
  logic [31:0] high_run;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_run <= 32'h0;
    end else begin
      high_run <= digital_output_one ? high_run + 32'h1 : 32'h0;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  property p_answer;
    s_setup |=> s_done;
  endproperty
  a_answer: assert property (p_answer) else $error("setup not answered");
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access)
    else $error("pready outside access");
  property p_one_cycle;
    s_done |=> !pready;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("pready held");
  property p_err_misaligned;
    s_done ##0 (paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  a_err_misaligned: assert property (p_err_misaligned)
    else $error("misaligned access accepted");
  property p_err_unmapped;
    s_done ##0 (paddr > 8'h5c) |-> pslverr && prdata == 32'h0;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped access accepted");
  property p_ctrl_reads_zero;
    s_done ##0 (!pwrite && paddr == 8'h00) |-> prdata == 32'h0;
  endproperty
  a_ctrl_reads_zero: assert property (p_ctrl_reads_zero)
    else $error("command word read not zero");
  property p_stop_closes;
    s_done ##0 (pwrite && paddr == 8'h00 && pwdata[1])
      |-> ##[1:2] !digital_output_two;
  endproperty
  a_stop_closes: assert property (p_stop_closes)
    else $error("valve open after stop");
  property p_pulse_cap;
    high_run <= 32'(PULSE_MAX);
  endproperty
  a_pulse_cap: assert property (p_pulse_cap)
    else $error("pulse longer than cap");
endmodule : flow_pulse_dosing_control_asserts

bind flow_pulse_dosing_control flow_pulse_dosing_control_asserts #(
  .PULSE_MAX(PULSE_MAX)
) u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .digital_output_one(digital_output_one),
  .digital_output_two(digital_output_two)
);

// file: tb/test_flow_pulse_dosing_control.sv
module test_flow_pulse_dosing_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 100;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic di, q1, q2, flow_valid;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, o;
  logic signed [31:0] flow_raw, analog_flow, rate;
  int failures, compares, pulses, n;
  // reset defaults of the settings words, 0x08 up to 0x28
  localparam logic [31:0] RV [9] = '{32'h0, 32'h1e, 32'h0, 32'hf, 32'h5,
    32'h0, 32'h0, 32'h2710, 32'ha};
  flow_pulse_dosing_control #(.TICK_LEN(TICK), .PULSE_MAX(1000)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flow_raw(flow_raw),
    .flow_valid(flow_valid), .digital_input_one(di),
    .digital_output_one(q1), .digital_output_two(q2),
    .analog_flow(analog_flow));
  flow_partner u_far (.pclk(pclk), .presetn(presetn), .rate(rate),
    .pulse(q1), .flow_raw(flow_raw), .flow_valid(flow_valid),
    .pulses(pulses));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one transfer; pready and the answer are taken at the rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) failures++;
  endtask : apb
  task automatic idle(input int c);
    repeat (c) @(negedge pclk);
  endtask : idle
  task automatic report_and_stop();
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // hard stop well beyond the expected run of about 66k cycles
  initial begin
    #400000;
    failures++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, di} = 5'h0;
    {paddr, pwdata, rate, failures, compares} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, 8'(8 + 4 * i), 32'h0);
      chk(rd, RV[i]);
    end
    apb(1'b0, 8'h60, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, 8'h10, 32'h258);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h1f4);
    apb(1'b1, 8'h28, 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h34, 32'h5);
    apb(1'b0, 8'h34, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    // safety timer of one step closes the valve on a huge target
    apb(1'b1, 8'h08, 32'hffffffff);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'd3500000);
    apb(1'b1, 8'h0c, 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    idle(3);
    chk(32'(q2), 32'h1);
    n = 0;
    while (q2 === 1'b1 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(n <= TICK + 2), 32'h1);
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    idle(4 * TICK);
    chk(32'(q2), 32'h1);
    apb(1'b1, 8'h00, 32'h2);
    idle(3);
    chk(32'(q2), 32'h0);
    // 8000 ml/s at 0.9 ml a pulse: about 8.9 kHz, under the ceiling
    apb(1'b1, 8'h28, 32'h9);
    @(posedge pclk);
    rate <= 32'sd800000;
    idle(60000);
    chk(32'(pulses), 32'h2);
    chk(analog_flow, 32'd800000);
    apb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h1);
    @(posedge pclk);
    rate <= 32'sd50;
    idle(2 * TICK);
    apb(1'b0, 8'h2c, 32'h0);
    chk(32'(rd[1]), 32'h0);
    idle(6 * TICK);
    apb(1'b0, 8'h2c, 32'h0);
    chk(32'(rd[1]), 32'h1);
    chk(analog_flow, 32'h0);
    n = pulses;
    idle(4000);
    chk(32'(pulses), 32'(n));
    apb(1'b1, 8'h04, 32'h34);
    @(posedge pclk);
    di <= 1'b1;
    idle(8);
    apb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h04, 32'h44);
    idle(40);
    apb(1'b0, 8'h38, 32'h0);
    o = rd;
    chk(32'(o != 32'h0), 32'h1);
    chk(analog_flow, 32'sd50 - o);
    apb(1'b1, 8'h00, 32'h4);
    idle(4);
    apb(1'b0, 8'h38, 32'h0);
    chk(rd, 32'd50);
    report_and_stop();
  end
endmodule : test_flow_pulse_dosing_control
